//--- include/rat_pkg.sv
package rat_pkg;
   localparam int NUM_TMR = 32;
   localparam int ACC_W = 14;
   localparam logic [13:0] ACC_MAX = 14'h270F; // 999.9 s in tenths
   localparam logic [13:0] ACC_ZERO = 14'h0000;
   localparam logic [13:0] RELOAD_RST = 14'h0000;
   localparam logic [13:0] PRESET_MIN = 14'h0001; // 000.1 s
   localparam logic [13:0] PRESET_RST = 14'h0001;
   // Rung-facing bit addresses
   localparam logic [9:0] TMR_BASE_ADDR = 10'h385; // 901
   localparam logic [9:0] OVF_ADDR_OFS = 10'h032; // 50
   // Time base
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS = 100000000; // 0.1 s
   localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 24;
   // APB byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FAULT = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_SEL = 8'h10;
   localparam logic [7:0] OFS_TYPE = 8'h14;
   localparam logic [7:0] OFS_PRESET = 8'h18;
   localparam logic [7:0] OFS_ACC = 8'h1C;
   localparam logic [7:0] OFS_RELOAD = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_OVF = 8'h28;
   // Control fields
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_TEST_BIT = 1;
   localparam int CTRL_PROT_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   // Interrupt fields
   localparam int IRQ_W = 3;
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_REACH_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;
   localparam logic [2:0] IRQ_RST = 3'h0;
   // Fault codes that wipe the timers
   localparam logic [7:0] FLT_LO = 8'h01;
   localparam logic [7:0] FLT_HI = 8'h09;
   localparam logic [7:0] FLT_EXP = 8'h1A; // 26
   localparam logic [7:0] FLT_EEP = 8'h33; // 51

   typedef struct packed {
      logic off_dly;
      logic [13:0] reload;
      logic [13:0] preset;
   } rat_cfg_t;

   localparam rat_cfg_t CFG_RST = '{off_dly: 1'b0, reload: RELOAD_RST, preset: PRESET_RST};

   typedef struct packed {
      logic sel;
      logic en;
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } rat_apb_req_t;
endpackage

//--- logic/rat_top.sv
// The register offsets and the APB register port were chosen for this implementation.
module rat_top #(
   parameter int TICK_CYC = rat_pkg::TICK_CYCLES
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic [31:0] EN_I,
   input wire logic [31:0] CLR_I,
   input wire logic [9:0] BIT_ADDR_I,
   output logic BIT_O,
   output logic [31:0] STATUS_O,
   output logic [31:0] OVF_O,
   output logic TICK_O,
   output logic IRQ_O
);
   localparam int N = rat_pkg::NUM_TMR;

   rat_pkg::rat_apb_req_t req;
   rat_pkg::rat_cfg_t cfg_r [N];
   logic [13:0] acc_r [N];
   logic [13:0] acc_nxt [N];
   logic [31:0] sts_r, sts_nxt, ovf_r, ovf_nxt;
   logic [31:0] arm_r, arm_nxt, en_prev_r;
   logic [31:0] inc_w, wrap_w, reach_w;
   logic [2:0] ctrl_r;
   logic [2:0] irq_stat_r, irq_mask_r, irq_set;
   logic [4:0] sel_r;
   logic [23:0] presc_r;
   logic tick_r;
   logic pready_r, pslverr_r, bit_r, irq_r;
   logic [31:0] prdata_r;

   // Request bundle and decode
   assign req = '{sel: PSEL_I, en: PENABLE_I, wr: PWRITE_I, addr: PADDR_I, wdata: PWDATA_I};
   wire acc_phase = req.sel && req.en && !pready_r;
   wire wr_go = acc_phase && req.wr;
   wire hit_ctrl = req.addr == rat_pkg::OFS_CTRL;
   wire hit_fault = req.addr == rat_pkg::OFS_FAULT;
   wire hit_istat = req.addr == rat_pkg::OFS_IRQ_STAT;
   wire hit_imask = req.addr == rat_pkg::OFS_IRQ_MASK;
   wire hit_sel = req.addr == rat_pkg::OFS_SEL;
   wire hit_type = req.addr == rat_pkg::OFS_TYPE;
   wire hit_pre = req.addr == rat_pkg::OFS_PRESET;
   wire hit_acc = req.addr == rat_pkg::OFS_ACC;
   wire hit_rel = req.addr == rat_pkg::OFS_RELOAD;
   wire hit_sts = req.addr == rat_pkg::OFS_STATUS;
   wire hit_ovf = req.addr == rat_pkg::OFS_OVF;
   wire hit_any = hit_ctrl | hit_fault | hit_istat | hit_imask | hit_sel | hit_type
                  | hit_pre | hit_acc | hit_rel | hit_sts | hit_ovf;
   wire run_mode = ctrl_r[rat_pkg::CTRL_RUN_BIT];
   wire test_mode = ctrl_r[rat_pkg::CTRL_TEST_BIT];
   wire prot = ctrl_r[rat_pkg::CTRL_PROT_BIT];
   wire [13:0] wval = req.wdata[13:0];
   wire val_ok = req.wdata[31:14] == 18'h00000 && wval <= rat_pkg::ACC_MAX;
   // Preset locked only while protected and in run or test
   wire pre_lock = prot && (run_mode || test_mode);
   wire pre_ok = val_ok && wval >= rat_pkg::PRESET_MIN && !pre_lock;
   wire wr_pre = wr_go && hit_pre && pre_ok;
   wire wr_acc = wr_go && hit_acc && val_ok;
   wire wr_rel = wr_go && hit_rel && val_ok;
   wire wr_bad = wr_go && ((hit_pre && !pre_ok) || ((hit_acc || hit_rel) && !val_ok)
                 || hit_sts || hit_ovf);
   wire [7:0] fcode = req.wdata[7:0];
   wire fault_hit = wr_go && hit_fault
                    && ((fcode >= rat_pkg::FLT_LO && fcode <= rat_pkg::FLT_HI)
                        || fcode == rat_pkg::FLT_EXP || fcode == rat_pkg::FLT_EEP);

   // Read mux
   wire [31:0] rd_mux =
      hit_ctrl ? {29'h00000000, ctrl_r} :
      hit_istat ? {29'h00000000, irq_stat_r} :
      hit_imask ? {29'h00000000, irq_mask_r} :
      hit_sel ? {27'h0000000, sel_r} :
      hit_type ? {31'h00000000, cfg_r[sel_r].off_dly} :
      hit_pre ? {18'h00000, cfg_r[sel_r].preset} :
      hit_acc ? {18'h00000, acc_r[sel_r]} :
      hit_rel ? {18'h00000, cfg_r[sel_r].reload} :
      hit_sts ? sts_r :
      hit_ovf ? ovf_r : 32'h00000000;

   // APB answer one cycle into the access phase; pready drops the next cycle
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= acc_phase;
         pslverr_r <= acc_phase && (!hit_any || wr_bad);
         prdata_r <= (acc_phase && !req.wr) ? rd_mux : 32'h00000000;
      end
   end

   // Control registers; mode bits only gate counting and preset writes, so state survives
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_r <= rat_pkg::CTRL_RST;
         irq_mask_r <= rat_pkg::IRQ_RST;
         sel_r <= 5'h00;
      end else begin
         if (wr_go && hit_ctrl) ctrl_r <= req.wdata[2:0];
         if (wr_go && hit_imask) irq_mask_r <= req.wdata[2:0];
         if (wr_go && hit_sel) sel_r <= req.wdata[4:0];
      end
   end

   // Shared 0.1 s prescaler
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         presc_r <= 24'h000000;
         tick_r <= 1'b0;
      end else begin
         tick_r <= presc_r == 24'(TICK_CYC - 1);
         presc_r <= (presc_r == 24'(TICK_CYC - 1)) ? 24'h000000 : presc_r + 24'h000001;
      end
   end

   // Per-timer next state; clear dominates, then sw write of the count
   always_comb begin
      for (int i = 0; i < N; i++) begin
         logic en, off;
         logic [13:0] inc_v;
         en = EN_I[i];
         off = cfg_r[i].off_dly;
         inc_v = (acc_r[i] == rat_pkg::ACC_MAX) ? rat_pkg::ACC_ZERO
                 : acc_r[i] + 14'h0001;
         inc_w[i] = run_mode && tick_r && !CLR_I[i]
                    && (off ? (arm_r[i] && !en) : en);
         wrap_w[i] = inc_w[i] && acc_r[i] == rat_pkg::ACC_MAX;
         reach_w[i] = inc_w[i] && !wrap_w[i] && inc_v == cfg_r[i].preset;
         acc_nxt[i] = acc_r[i];
         sts_nxt[i] = sts_r[i];
         ovf_nxt[i] = ovf_r[i];
         arm_nxt[i] = arm_r[i];
         if (CLR_I[i]) begin
            sts_nxt[i] = 1'b0;
            ovf_nxt[i] = 1'b0;
            acc_nxt[i] = cfg_r[i].reload;
            arm_nxt[i] = 1'b0;
         end else begin
            if (off && en && !en_prev_r[i]) sts_nxt[i] = 1'b1;
            if (off && !en && en_prev_r[i]) arm_nxt[i] = 1'b1;
            if (inc_w[i]) acc_nxt[i] = inc_v;
            if (wrap_w[i]) ovf_nxt[i] = 1'b1;
            if (reach_w[i]) sts_nxt[i] = !off;
            if (wr_acc && sel_r == 5'(i)) acc_nxt[i] = wval;
         end
      end
   end

   // Timer state; reset or a fatal fault zeroes all timers, CLR_I zeroes one timer's bits and loads its reload
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (int i = 0; i < N; i++) acc_r[i] <= rat_pkg::ACC_ZERO;
         sts_r <= 32'h00000000;
         ovf_r <= 32'h00000000;
         arm_r <= 32'h00000000;
         en_prev_r <= 32'h00000000;
      end else if (fault_hit) begin
         for (int i = 0; i < N; i++) acc_r[i] <= rat_pkg::ACC_ZERO;
         sts_r <= 32'h00000000;
         ovf_r <= 32'h00000000;
         arm_r <= 32'h00000000;
         en_prev_r <= EN_I;
      end else begin
         for (int i = 0; i < N; i++) acc_r[i] <= acc_nxt[i];
         sts_r <= sts_nxt;
         ovf_r <= ovf_nxt;
         arm_r <= arm_nxt;
         en_prev_r <= EN_I;
      end
   end

   // Timer configuration
   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (int i = 0; i < N; i++) cfg_r[i] <= rat_pkg::CFG_RST;
      end else if (fault_hit) begin
         for (int i = 0; i < N; i++) cfg_r[i] <= rat_pkg::CFG_RST;
      end else begin
         if (wr_pre) cfg_r[sel_r].preset <= wval;
         if (wr_rel) cfg_r[sel_r].reload <= wval;
         if (wr_go && hit_type) cfg_r[sel_r].off_dly <= req.wdata[0];
      end
   end

   // Rung bit read: status at 901+i, overflow at 951+i
   wire [9:0] st_idx = BIT_ADDR_I - rat_pkg::TMR_BASE_ADDR;
   wire [9:0] ov_idx = st_idx - rat_pkg::OVF_ADDR_OFS;
   wire st_hit = BIT_ADDR_I >= rat_pkg::TMR_BASE_ADDR && st_idx < 10'(N);
   wire ov_hit = BIT_ADDR_I >= rat_pkg::TMR_BASE_ADDR + rat_pkg::OVF_ADDR_OFS
                 && ov_idx < 10'(N);
   wire bit_nxt = st_hit ? sts_r[st_idx[4:0]] : ov_hit ? ovf_r[ov_idx[4:0]] : 1'b0;

   // Sticky events; a new event in the clearing cycle survives
   assign irq_set = {fault_hit, |reach_w, |wrap_w};
   wire [2:0] irq_clr = (wr_go && hit_istat) ? req.wdata[2:0] : 3'h0;
   wire [2:0] irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_stat_r <= rat_pkg::IRQ_RST;
         irq_r <= 1'b0;
         bit_r <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r <= |(irq_stat_nxt & irq_mask_r);
         bit_r <= bit_nxt;
      end
   end

   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign BIT_O = bit_r;
   assign STATUS_O = sts_r;
   assign OVF_O = ovf_r;
   assign TICK_O = tick_r;
   assign IRQ_O = irq_r;

   // Checks on timer 0 and shared logic
   a_ton_count: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (run_mode && tick_r && EN_I[0] && !CLR_I[0] && !cfg_r[0].off_dly && !fault_hit
       && !wr_acc && acc_r[0] != rat_pkg::ACC_MAX) |=> acc_r[0] == $past(acc_r[0]) + 14'h0001)
      else $error("on-delay count did not advance");
   a_ton_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (!EN_I[0] && !cfg_r[0].off_dly && !CLR_I[0] && !wr_acc && !fault_hit)
      |=> acc_r[0] == $past(acc_r[0]))
      else $error("on-delay count moved with rung false");
   a_toff_idle: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (cfg_r[0].off_dly && (EN_I[0] || !arm_r[0])) |-> !inc_w[0])
      else $error("off-delay counted while rung true or unarmed");
   a_ton_reach: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (reach_w[0] && !cfg_r[0].off_dly && !fault_hit) |=> sts_r[0] ##1 sts_r[0] || CLR_I[0]
      || fault_hit)
      else $error("on-delay status not set at preset");
   a_toff_rise: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (cfg_r[0].off_dly && $rose(EN_I[0]) && !CLR_I[0] && !fault_hit) |=> sts_r[0])
      else $error("off-delay status not set on rising rung");
   a_wrap_ovf: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (wrap_w[0] && !fault_hit && !wr_acc)
      |=> acc_r[0] == rat_pkg::ACC_ZERO && ovf_r[0] && sts_r[0] == $past(sts_r[0]))
      else $error("wrap did not zero count or set overflow");
   a_clr_load: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CLR_I[0] && !fault_hit) |=> !sts_r[0] && !ovf_r[0] && acc_r[0] == $past(cfg_r[0].reload))
      else $error("clear did not reload timer");
   a_fault_wipe: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      fault_hit |=> sts_r == 32'h00000000 && ovf_r == 32'h00000000
      && acc_r[0] == rat_pkg::ACC_ZERO)
      else $error("fault did not wipe timers");
   a_tick_gap: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      tick_r |=> !tick_r)
      else $error("tick longer than one cycle");
   a_prot_pre: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (wr_go && hit_pre && pre_lock && !fault_hit)
      |=> cfg_r[$past(sel_r)].preset == $past(cfg_r[sel_r].preset))
      else $error("protected preset changed");

   // Further checks: bit retention, clear gating, bit readout and timing
   a_toff_reach: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (reach_w[0] && cfg_r[0].off_dly && !fault_hit) |=> !sts_r[0])
      else $error("off-delay status not cleared at preset");

   a_ton_keep: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (sts_r[0] && !cfg_r[0].off_dly && !CLR_I[0] && !fault_hit) |=> sts_r[0])
      else $error("on-delay status dropped while counting");

   a_ovf_sticky: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (ovf_r[0] && !CLR_I[0] && !fault_hit) |=> ovf_r[0])
      else $error("overflow bit dropped without clear");

   a_clr_stop: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      CLR_I[0] |-> !inc_w[0])
      else $error("timer counted while clear held");

   a_clr_disarm: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (CLR_I[0] && !fault_hit) |=> !arm_r[0])
      else $error("off-delay still armed after clear");

   a_toff_arm: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (cfg_r[0].off_dly && $fell(EN_I[0]) && !CLR_I[0] && !fault_hit) |=> arm_r[0])
      else $error("off-delay not armed by falling rung");

   a_wrap_count: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (inc_w[0] && acc_r[0] == rat_pkg::ACC_ZERO && !wr_acc && !fault_hit)
      |=> acc_r[0] == 14'h0001)
      else $error("count did not continue from zero");

   a_acc_range: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      acc_r[0] <= rat_pkg::ACC_MAX)
      else $error("count out of range");

   a_pre_range: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      cfg_r[0].preset >= rat_pkg::PRESET_MIN && cfg_r[0].preset <= rat_pkg::ACC_MAX)
      else $error("preset out of range");

   a_rel_range: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      cfg_r[0].reload <= rat_pkg::ACC_MAX)
      else $error("reload out of range");

   a_bit_sts: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (BIT_ADDR_I == rat_pkg::TMR_BASE_ADDR) |=> BIT_O == $past(sts_r[0]))
      else $error("status bit readout wrong");

   a_bit_ovf: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (BIT_ADDR_I == rat_pkg::TMR_BASE_ADDR + rat_pkg::OVF_ADDR_OFS) |=> BIT_O == $past(ovf_r[0]))
      else $error("overflow bit readout wrong");

   a_mode_keep: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (wr_go && hit_ctrl && !CLR_I[0] && !inc_w[0]) |=> acc_r[0] == $past(acc_r[0]))
      else $error("mode change disturbed count");

   a_tick_align: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      tick_r |-> presc_r == 24'h000000)
      else $error("tick not aligned to prescaler wrap");

   a_acc_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (wr_acc && sel_r == 5'h00 && !CLR_I[0]) |=> acc_r[0] == $past(wval))
      else $error("count write lost");

   a_apb_pulse: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      pready_r |=> !pready_r)
      else $error("ready longer than one cycle");

   a_irq_sticky: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (irq_stat_r[rat_pkg::IRQ_OVF_BIT] && !(wr_go && hit_istat && req.wdata[0]))
      |=> irq_stat_r[rat_pkg::IRQ_OVF_BIT])
      else $error("overflow event dropped without clear");
endmodule

//--- testbench/rat_rung.sv
module rat_rung (
   input wire logic clk_i,
   input wire logic bit_i,
   output logic [31:0] en_o,
   output logic [31:0] clr_o,
   output logic [9:0] addr_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Rungs start false, no clear, no bit addressed
   initial begin
      en_o = 32'h0;
      clr_o = 32'h0;
      addr_o = 10'h000;
   end

   // One rung scan: enable and clear change just after an edge
   task automatic rung(input int i, input logic e, input logic c);
      @(posedge clk_i);
      en_o[i] <= e;
      clr_o[i] <= c;
   endtask

   // Bit read waits out the one-cycle register lag
   task automatic peek(input logic [9:0] a, output logic v);
      @(posedge clk_i);
      addr_o <= a;
      @(posedge clk_i);
      @(negedge clk_i);
      v = bit_i;
   endtask
endmodule

//--- testbench/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TC = 16; // Short tick, still leaves room for a bus write between ticks
   typedef struct {
      logic off;
      logic [13:0] pre;
      logic [13:0] rel;
      int n;
      logic [13:0] acc;
      logic st;
      logic ov;
   } rat_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd, en, clr, rd, st, ovf;
   logic pready, perr, bitv, tick, irq, v;
   logic [9:0] baddr;
   int n_fail = 0;
   int num_checks = 0;
   int cyc;
   // Type, preset, reload, ticks, then count, status, overflow
   rat_row_t rows[6] = '{
      '{1'b0, 14'h0003, 14'h0000, 3, 14'h0003, 1'b1, 1'b0},
      '{1'b0, 14'h0005, 14'h0002, 2, 14'h0004, 1'b0, 1'b0},
      '{1'b0, 14'h0002, 14'h0000, 4, 14'h0004, 1'b1, 1'b0},
      '{1'b1, 14'h0003, 14'h0000, 3, 14'h0003, 1'b0, 1'b0},
      '{1'b1, 14'h0004, 14'h0001, 2, 14'h0003, 1'b1, 1'b0},
      '{1'b0, 14'h270F, 14'h270F, 2, 14'h0001, 1'b0, 1'b1}
   };
   logic [7:0] codes[5] = '{8'h0A, 8'h01, 8'h09, 8'h1A, 8'h33};

   always #4 clk = ~clk;

   rat_top #(.TICK_CYC(TC)) i_rat_top (
      .SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(pready),
      .PSLVERR_O(perr), .EN_I(en), .CLR_I(clr), .BIT_ADDR_I(baddr), .BIT_O(bitv),
      .STATUS_O(st), .OVF_O(ovf), .TICK_O(tick), .IRQ_O(irq));
   rat_rung i_rat_rung (.clk_i(clk), .bit_i(bitv), .en_o(en), .clr_o(clr), .addr_o(baddr));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Bus cycle: request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic err, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prd;
      chk(perr, err, "slverr");
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d, e, rd);
   endtask

   task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0, rd);
      chk(rd, exp, "read");
   endtask

   // Returns at the edge that ends the n-th tick cycle
   task automatic ticks(input int n);
      repeat (n) begin
         do @(posedge clk); while (tick !== 1'b1);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard at 50000 cycles, far beyond the thousand or so cycles the tests need
   initial begin
      #400000;
      n_fail++;
      $display("BAD t=%0t watchdog", $time);
      wrap_up;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdx(rat_pkg::OFS_PRESET, 32'h1);
      rdx(rat_pkg::OFS_RELOAD, 32'h0);
      rdx(rat_pkg::OFS_ACC, 32'h0);
      ticks(1);
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
      end while (tick !== 1'b1);
      chk(cyc, TC, "tick spacing");
      $display("reset and tick done");
      // Each row times one timer, stopped by leaving run mode
      foreach (rows[i]) begin
         wr(rat_pkg::OFS_SEL, 32'(i), 1'b0);
         wr(rat_pkg::OFS_TYPE, {31'h0, rows[i].off}, 1'b0);
         wr(rat_pkg::OFS_PRESET, {18'h0, rows[i].pre}, 1'b0);
         wr(rat_pkg::OFS_RELOAD, {18'h0, rows[i].rel}, 1'b0);
         i_rat_rung.rung(i, 1'b0, 1'b1);
         i_rat_rung.rung(i, 1'b0, 1'b0);
         rdx(rat_pkg::OFS_ACC, {18'h0, rows[i].rel});
         wr(rat_pkg::OFS_CTRL, 32'h1, 1'b0);
         ticks(1);
         i_rat_rung.rung(i, 1'b1, 1'b0);
         if (rows[i].off) begin
            i_rat_rung.rung(i, 1'b0, 1'b0);
            @(posedge clk);
            @(negedge clk);
            chk(st[i], 1'b1, "off status");
         end
         ticks(rows[i].n);
         wr(rat_pkg::OFS_CTRL, 32'h0, 1'b0);
         i_rat_rung.rung(i, 1'b0, 1'b0);
         ticks(1);
         rdx(rat_pkg::OFS_ACC, {18'h0, rows[i].acc});
         i_rat_rung.peek(rat_pkg::TMR_BASE_ADDR + 10'(i), v);
         chk(v, rows[i].st, "status bit");
         i_rat_rung.peek(rat_pkg::TMR_BASE_ADDR + rat_pkg::OVF_ADDR_OFS + 10'(i), v);
         chk(v, rows[i].ov, "overflow bit");
         chk(ovf[i], rows[i].ov, "overflow out");
      end
      $display("timer rows done");
      // Interrupt: raised, masked, cleared
      rdx(rat_pkg::OFS_IRQ_STAT, 32'h3);
      chk(irq, 1'b0, "irq masked");
      wr(rat_pkg::OFS_IRQ_MASK, 32'h1, 1'b0);
      repeat (2) @(negedge clk);
      chk(irq, 1'b1, "irq unmasked");
      wr(rat_pkg::OFS_IRQ_STAT, 32'h1, 1'b0);
      repeat (2) @(negedge clk);
      chk(irq, 1'b0, "irq cleared");
      rdx(rat_pkg::OFS_IRQ_STAT, 32'h2);
      $display("interrupt done");
      // Clear held across ticks keeps the timer at reload
      wr(rat_pkg::OFS_SEL, 32'h0, 1'b0);
      wr(rat_pkg::OFS_CTRL, 32'h1, 1'b0);
      i_rat_rung.rung(0, 1'b1, 1'b1);
      ticks(2);
      rdx(rat_pkg::OFS_ACC, 32'h0);
      chk(st[0], 1'b0, "held clear status");
      i_rat_rung.rung(0, 1'b1, 1'b0);
      ticks(1);
      i_rat_rung.rung(0, 1'b0, 1'b0);
      rdx(rat_pkg::OFS_ACC, 32'h1);
      $display("clear done");
      // Refused writes answer with slverr; preset still writable when protected but stopped
      wr(rat_pkg::OFS_CTRL, 32'h5, 1'b0);
      wr(rat_pkg::OFS_PRESET, 32'h7, 1'b1);
      wr(rat_pkg::OFS_ACC, 32'h7, 1'b0);
      wr(rat_pkg::OFS_CTRL, 32'h6, 1'b0);
      wr(rat_pkg::OFS_PRESET, 32'h7, 1'b1);
      wr(rat_pkg::OFS_CTRL, 32'h4, 1'b0);
      wr(rat_pkg::OFS_PRESET, 32'h6, 1'b0);
      wr(rat_pkg::OFS_CTRL, 32'h0, 1'b0);
      rdx(rat_pkg::OFS_PRESET, 32'h6);
      wr(rat_pkg::OFS_PRESET, 32'h0, 1'b1);
      wr(rat_pkg::OFS_RELOAD, 32'h2710, 1'b1);
      wr(8'h3C, 32'h0, 1'b1);
      $display("refusals done");
      // Only the listed fault codes wipe the timers
      foreach (codes[k]) begin
         wr(rat_pkg::OFS_ACC, 32'h5, 1'b0);
         wr(rat_pkg::OFS_FAULT, {24'h0, codes[k]}, 1'b0);
         rdx(rat_pkg::OFS_ACC, (k == 0) ? 32'h5 : 32'h0);
      end
      rdx(rat_pkg::OFS_PRESET, 32'h1);
      $display("faults done");
      wrap_up;
   end
endmodule
